// ==== include/aerm_pkg.sv ====
// Package: constants, register map and types of the absolute-encoder request monitor
package aerm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned AERM_CLK_HZ = 40_000_000;
   localparam int unsigned AERM_CLK_KHZ = AERM_CLK_HZ / 1000;
   localparam int unsigned AERM_VALID_MS = 5000;
   localparam int unsigned AERM_WINDOW_MS = 4000;
   localparam int unsigned AERM_REQ_DELAY_MS = 100;
   localparam int unsigned AERM_POST_DELAY_MS = 400;
   // Whole milliseconds at a whole kHz rate are exact, so no rounding is needed
   localparam logic [31:0] AERM_VALID_CYC = 32'(AERM_VALID_MS * AERM_CLK_KHZ);
   localparam logic [31:0] AERM_WINDOW_CYC = 32'(AERM_WINDOW_MS * AERM_CLK_KHZ);
   localparam logic [31:0] AERM_REQ_DELAY_CYC = 32'(AERM_REQ_DELAY_MS * AERM_CLK_KHZ);
   localparam logic [31:0] AERM_POST_DELAY_CYC = 32'(AERM_POST_DELAY_MS * AERM_CLK_KHZ);
   localparam logic [3:0] AERM_CHAR_LAST = 4'h7;
   localparam int AERM_NSYNC = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam int AERM_AW = 8;
   localparam logic [7:0] AERM_OFS_CFG = 8'h00;
   localparam logic [7:0] AERM_OFS_CTRL = 8'h04;
   localparam logic [7:0] AERM_OFS_STATUS = 8'h08;
   localparam logic [7:0] AERM_OFS_MTURN = 8'h0c;
   localparam logic [7:0] AERM_OFS_INCCNT = 8'h10;
   localparam logic [7:0] AERM_OFS_T_VALID = 8'h14;
   localparam logic [7:0] AERM_OFS_T_WIN = 8'h18;
   localparam logic [7:0] AERM_OFS_T_REQ = 8'h1c;
   localparam logic [7:0] AERM_OFS_T_POST = 8'h20;

   // Field positions
   localparam int AERM_CFG_INCR_BIT = 0;
   localparam int AERM_CFG_WARN_BIT = 1;
   localparam int AERM_CTRL_RESTART_BIT = 0;
   localparam int AERM_ST_INCR_BIT = 0;
   localparam int AERM_ST_WARN_MODE_BIT = 1;
   localparam int AERM_ST_SERVING_BIT = 2;
   localparam int AERM_ST_ALM_VALID_BIT = 3;
   localparam int AERM_ST_WIN_OPEN_BIT = 4;
   localparam int AERM_ST_ALARM_BIT = 5;
   localparam int AERM_ST_WARNING_BIT = 6;
   localparam int AERM_ST_SERVO_BIT = 7;
   localparam int AERM_ST_SEQ_LSB = 8;

   // Reset values
   localparam logic [1:0] AERM_CFG_RESET = 2'h0;
   localparam logic [15:0] AERM_MTURN_RESET = 16'h0000;

   // Bus responses
   localparam logic [1:0] AERM_RESP_OKAY = 2'h0;
   localparam logic [1:0] AERM_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic warn_mode;
      logic incr_mode;
   } aerm_cfg_t;

   typedef enum logic [4:0] {
      AERM_IDLE = 5'b00001,
      AERM_WAIT = 5'b00010,
      AERM_SEND = 5'b00100,
      AERM_POST = 5'b01000,
      AERM_DONE = 5'b10000
   } aerm_seq_t;

   typedef struct packed {
      logic battery_low;
      logic servo_on;
      logic request;
   } aerm_pins_t;

endpackage

// ==== rtl/aerm_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module aerm_sync
   import aerm_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire aerm_pins_t pin_in,
   output aerm_pins_t pin_out
);

   typedef struct packed {
      aerm_pins_t s1;
      aerm_pins_t s2;
      aerm_pins_t s3;
      aerm_pins_t q;
   } aerm_sync_state_t;

   aerm_sync_state_t s;
   aerm_sync_state_t next_s;

   ////////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second; output moves once stages two and three agree
   always_comb
   begin
      next_s = s;
      next_s.s1 = pin_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.q = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign pin_out = s.q;

endmodule // aerm_sync
`default_nettype wire

// ==== rtl/aerm_monitor.sv ====
// Absolute-encoder request monitor with AXI4-Lite register slave
//
// Behaviour
// RULE1: Mode digit 0 absolute, 1 incremental, after restart
// RULE2: Incremental mode ignores request and battery
// RULE3: Multiturn count forward wraps +32767 to -32768
// RULE4: Multiturn count reverse wraps -32768 to +32767
// RULE5: Request high asks data; low means none
// RULE6: Servo-on ignored while request is served
// RULE7: Host drops request before removing power
// RULE8: Low battery raises alarm or warning, never both; an alarm latched before a restart into digit 1 stays on beside the warning
// RULE9: Report digit 0 alarm, 1 warning, after restart
// RULE10: Digit 0 checks battery only in window
// RULE11: Digit 1 checks battery continuously once valid
// RULE12: Battery alarm clears only on power cycle
// RULE13: After delay, wait to send, clear counter
// RULE14: Send eight characters, then delay, normal
// RULE15: Timings come from programmable cycle counters
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module aerm_monitor
   import aerm_pkg::*;
#(
   parameter logic [31:0] VALID_CYC = AERM_VALID_CYC,
   parameter logic [31:0] WINDOW_CYC = AERM_WINDOW_CYC,
   parameter logic [31:0] REQ_DELAY_CYC = AERM_REQ_DELAY_CYC,
   parameter logic [31:0] POST_DELAY_CYC = AERM_POST_DELAY_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [AERM_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AERM_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins from the host and the battery comparator
   input wire aerm_pins_t pins,
   // Encoder and formatter events on this clock
   input wire logic turn_fwd,
   input wire logic turn_rev,
   input wire logic inc_up,
   input wire logic inc_down,
   input wire logic char_done,
   // Drive outputs
   output logic char_send_req,
   output logic abs_serving,
   output logic servo_power_en,
   output logic fault_output,
   output logic battery_warning
);

   typedef struct packed {
      aerm_cfg_t cfg_pend;
      aerm_cfg_t cfg_act;
      logic [31:0] t_valid;
      logic [31:0] t_win;
      logic [31:0] t_req;
      logic [31:0] t_post;
      logic [31:0] pwr_cnt;
      logic alm_valid;
      logic [31:0] win_cnt;
      logic win_open;
      aerm_seq_t seq;
      logic [31:0] seq_cnt;
      logic [3:0] chars;
      logic char_req;
      logic [15:0] mturn;
      logic [15:0] inc_cnt;
      logic bat_alarm;
      logic bat_warn;
      logic servo_en;
      logic serving;
      logic aw_have;
      logic [AERM_AW-1:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic aw_rdy;
      logic w_rdy;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } aerm_state_t;

   aerm_state_t s;
   aerm_state_t next_s;
   aerm_pins_t pin_q;

   aerm_sync u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(pins),
      .pin_out(pin_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[8*i +: 8] = data[8*i +: 8];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      logic [31:0] wv;
      logic detect;
      logic waddr_ok;
      logic req_on;
      wv = '0;
      detect = 1'b0;
      waddr_ok = 1'b0;
      req_on = 1'b0;
      next_s = s;

      // Write channel capture, address and data in either order
      if (s_axi_awvalid && s.aw_rdy)
      begin
         next_s.aw_have = 1'b1;
         next_s.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.w_rdy)
      begin
         next_s.w_have = 1'b1;
         next_s.w_data = s_axi_wdata;
         next_s.w_strb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready)
         next_s.bvalid = 1'b0;

      // Power-up validity of the fault output, then the detection window
      if (!s.alm_valid)
      begin
         next_s.pwr_cnt = s.pwr_cnt + 32'h1; // RULE15
         if (s.pwr_cnt + 32'h1 >= s.t_valid)
         begin
            next_s.alm_valid = 1'b1;
            next_s.win_open = 1'b1;
            next_s.win_cnt = '0;
         end
      end
      if (s.win_open)
      begin
         next_s.win_cnt = s.win_cnt + 32'h1; // RULE15
         if (s.win_cnt + 32'h1 >= s.t_win)
            next_s.win_open = 1'b0; // RULE10
      end

      // Battery is irrelevant in incremental mode
      detect = pin_q.battery_low && s.alm_valid && !s.cfg_act.incr_mode // RULE2
               && (s.cfg_act.warn_mode || s.win_open); // RULE10 RULE11
      if (detect && !s.cfg_act.warn_mode)
         next_s.bat_alarm = 1'b1; // RULE8 RULE12
      next_s.bat_warn = detect && s.cfg_act.warn_mode; // RULE8 RULE9

      // Multiturn count wraps through the 16-bit two's complement range
      if (turn_fwd && !turn_rev)
         next_s.mturn = s.mturn + 16'h0001; // RULE3
      else if (turn_rev && !turn_fwd)
         next_s.mturn = s.mturn - 16'h0001; // RULE4

      if (inc_up && !inc_down)
         next_s.inc_cnt = s.inc_cnt + 16'h0001;
      else if (inc_down && !inc_up)
         next_s.inc_cnt = s.inc_cnt - 16'h0001;

      // Request sequencer; a dropped request abandons the transfer at once
      req_on = pin_q.request && !s.cfg_act.incr_mode; // RULE2 RULE5
      next_s.char_req = 1'b0;
      case (s.seq)
         AERM_IDLE:
         begin
            if (req_on)
            begin
               next_s.seq = AERM_WAIT;
               next_s.seq_cnt = '0;
            end
         end
         AERM_WAIT:
         begin
            next_s.seq_cnt = s.seq_cnt + 32'h1; // RULE15
            if (s.seq_cnt + 32'h1 >= s.t_req)
            begin
               next_s.seq = AERM_SEND; // RULE13
               next_s.inc_cnt = '0; // RULE13
               next_s.chars = '0;
               next_s.char_req = 1'b1;
            end
         end
         AERM_SEND:
         begin
            if (char_done)
            begin
               next_s.chars = s.chars + 4'h1;
               if (s.chars == AERM_CHAR_LAST)
               begin
                  next_s.seq = AERM_POST; // RULE14
                  next_s.seq_cnt = '0;
               end
               else
                  next_s.char_req = 1'b1; // RULE14
            end
         end
         AERM_POST:
         begin
            next_s.seq_cnt = s.seq_cnt + 32'h1;
            if (s.seq_cnt + 32'h1 >= s.t_post)
               next_s.seq = AERM_DONE; // RULE14
         end
         AERM_DONE:
         begin
            next_s.seq = AERM_DONE;
         end
         default:
         begin
            next_s.seq = AERM_IDLE;
         end
      endcase
      if (!req_on)
      begin
         next_s.seq = AERM_IDLE; // RULE5
         next_s.char_req = 1'b0;
      end

      // Register write, taken once both halves are held and the response is free
      if (s.aw_have && s.w_have && !s.bvalid)
      begin
         waddr_ok = 1'b1;
         if (s.aw_addr == AERM_OFS_CFG)
         begin
            wv = merge({30'h0, s.cfg_pend}, s.w_data, s.w_strb);
            next_s.cfg_pend.incr_mode = wv[AERM_CFG_INCR_BIT];
            next_s.cfg_pend.warn_mode = wv[AERM_CFG_WARN_BIT];
         end
         else if (s.aw_addr == AERM_OFS_CTRL)
         begin
            // Restart reloads modes and reruns power-up timing; the alarm survives
            if (s.w_strb[0] && s.w_data[AERM_CTRL_RESTART_BIT])
            begin
               next_s.cfg_act = s.cfg_pend; // RULE1 RULE9
               next_s.pwr_cnt = '0;
               next_s.alm_valid = 1'b0;
               next_s.win_open = 1'b0;
               next_s.win_cnt = '0;
               next_s.seq = AERM_IDLE;
               next_s.char_req = 1'b0;
            end
         end
         else if (s.aw_addr == AERM_OFS_T_VALID)
            next_s.t_valid = merge(s.t_valid, s.w_data, s.w_strb); // RULE15
         else if (s.aw_addr == AERM_OFS_T_WIN)
            next_s.t_win = merge(s.t_win, s.w_data, s.w_strb); // RULE15
         else if (s.aw_addr == AERM_OFS_T_REQ)
            next_s.t_req = merge(s.t_req, s.w_data, s.w_strb); // RULE15
         else if (s.aw_addr == AERM_OFS_T_POST)
            next_s.t_post = merge(s.t_post, s.w_data, s.w_strb); // RULE15
         else if (s.aw_addr == AERM_OFS_STATUS || s.aw_addr == AERM_OFS_MTURN
                  || s.aw_addr == AERM_OFS_INCCNT)
            waddr_ok = 1'b1;
         else
            waddr_ok = 1'b0;
         next_s.aw_have = 1'b0;
         next_s.w_have = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = waddr_ok ? AERM_RESP_OKAY : AERM_RESP_SLVERR;
      end
      next_s.aw_rdy = !next_s.aw_have;
      next_s.w_rdy = !next_s.w_have;

      // Register read, one outstanding
      if (s.rvalid && s_axi_rready)
         next_s.rvalid = 1'b0;
      if (s_axi_arvalid && s.ar_rdy)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp = AERM_RESP_OKAY;
         next_s.rdata = '0;
         if (s_axi_araddr == AERM_OFS_CFG)
            next_s.rdata = {30'h0, s.cfg_pend};
         else if (s_axi_araddr == AERM_OFS_CTRL)
            next_s.rdata = '0;
         else if (s_axi_araddr == AERM_OFS_STATUS)
         begin
            next_s.rdata[AERM_ST_INCR_BIT] = s.cfg_act.incr_mode;
            next_s.rdata[AERM_ST_WARN_MODE_BIT] = s.cfg_act.warn_mode;
            next_s.rdata[AERM_ST_SERVING_BIT] = (s.seq != AERM_IDLE) && (s.seq != AERM_DONE);
            next_s.rdata[AERM_ST_ALM_VALID_BIT] = s.alm_valid;
            next_s.rdata[AERM_ST_WIN_OPEN_BIT] = s.win_open;
            next_s.rdata[AERM_ST_ALARM_BIT] = s.bat_alarm;
            next_s.rdata[AERM_ST_WARNING_BIT] = s.bat_warn;
            next_s.rdata[AERM_ST_SERVO_BIT] = s.servo_en;
            next_s.rdata[AERM_ST_SEQ_LSB +: 5] = s.seq;
         end
         else if (s_axi_araddr == AERM_OFS_MTURN)
            next_s.rdata = {{16{s.mturn[15]}}, s.mturn};
         else if (s_axi_araddr == AERM_OFS_INCCNT)
            next_s.rdata = {{16{s.inc_cnt[15]}}, s.inc_cnt};
         else if (s_axi_araddr == AERM_OFS_T_VALID)
            next_s.rdata = s.t_valid;
         else if (s_axi_araddr == AERM_OFS_T_WIN)
            next_s.rdata = s.t_win;
         else if (s_axi_araddr == AERM_OFS_T_REQ)
            next_s.rdata = s.t_req;
         else if (s_axi_araddr == AERM_OFS_T_POST)
            next_s.rdata = s.t_post;
         else
            next_s.rresp = AERM_RESP_SLVERR;
      end
      next_s.ar_rdy = !next_s.rvalid;

      // Motor power only outside the served interval and without an alarm
      next_s.servo_en = pin_q.servo_on && !next_s.bat_alarm // RULE6
                        && (next_s.seq == AERM_IDLE || next_s.seq == AERM_DONE); // RULE6
      // Registered so the pin comes straight from a flop, in step with the state
      next_s.serving = next_s.seq[1] | next_s.seq[2] | next_s.seq[3]; // RULE6
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; control power loss is the only clear of the alarm
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.cfg_pend <= AERM_CFG_RESET;
         s.cfg_act <= AERM_CFG_RESET;
         s.t_valid <= VALID_CYC;
         s.t_win <= WINDOW_CYC;
         s.t_req <= REQ_DELAY_CYC;
         s.t_post <= POST_DELAY_CYC;
         s.mturn <= AERM_MTURN_RESET;
         s.seq <= AERM_IDLE;
         s.bat_alarm <= 1'b0; // RULE12
      end
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready = s.aw_rdy;
   assign s_axi_wready = s.w_rdy;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.ar_rdy;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign char_send_req = s.char_req;
   assign abs_serving = s.serving;
   assign servo_power_en = s.servo_en;
   assign fault_output = s.bat_alarm;
   assign battery_warning = s.bat_warn;

endmodule // aerm_monitor
`default_nettype wire

// ==== testbench/aerm_host_model.sv ====
// Host controller and character formatter model facing the monitor
`timescale 1ns/100ps
`default_nettype none
module aerm_host_model
   import aerm_pkg::*;
(
   input wire logic aclk,
   input wire logic want_data,
   input wire logic want_servo,
   input wire logic power_down,
   input wire logic batt_low,
   input wire logic [7:0] done_dly,
   input wire logic char_send_req,
   output aerm_pins_t pins,
   output logic char_done
);
   logic [7:0] cnt = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin levels move only after an edge, as a real host output would
   always @(posedge aclk)
   begin
      pins.request <= want_data && !power_down;
      pins.servo_on <= want_servo;
      pins.battery_low <= batt_low;
      // Delay of 1 answers promptly, larger values model a slow formatter
      char_done <= cnt == 8'h01;
      if (char_send_req)
         cnt <= (done_dly == 8'h00) ? 8'h01 : done_dly;
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
   end
endmodule // aerm_host_model
`default_nettype wire

// ==== testbench/aerm_monitor_properties.sv ====
// Checker: port-level properties of the request monitor
`timescale 1ns/100ps
`default_nettype none
module aerm_monitor_properties
   import aerm_pkg::*;
#(
   parameter logic [31:0] REQ_DELAY_CYC = AERM_REQ_DELAY_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire aerm_pins_t pins,
   input wire logic char_send_req,
   input wire logic abs_serving,
   input wire logic servo_power_en,
   input wire logic fault_output,
   input wire logic battery_warning
);
   logic [31:0] serve_cnt;
   logic [3:0] chars;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Cycles spent serving and characters asked for within one request
   always_ff @(posedge aclk)
   begin
      serve_cnt <= (aresetn && abs_serving) ? serve_cnt + 32'h1 : 32'h0;
      if (!aresetn || !abs_serving)
         chars <= 4'h0;
      else if (char_send_req && chars != 4'hf)
         chars <= chars + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One cycle of slack: servo power is a registered output
   AST_SERVO_BLOCKED: assert property (abs_serving && $past(abs_serving) |-> !servo_power_en)
      else $error("servo power on while request served");
   AST_ONE_REPORT: assert property (!(fault_output && battery_warning))
      else $error("alarm and warning together");
   AST_ALARM_HELD: assert property (fault_output |=> fault_output)
      else $error("alarm cleared without power cycle");
   AST_CHAR_PULSE: assert property (char_send_req |=> !char_send_req)
      else $error("character request longer than one cycle");
   AST_CHAR_IN_SERVE: assert property (char_send_req |-> abs_serving)
      else $error("character request outside a sequence");
   AST_REQ_LOW_IDLE: assert property (!pins.request [*7] |-> !abs_serving)
      else $error("serving without request");
   AST_REQ_DELAY: assert property (char_send_req && chars == 4'h0 |->
      serve_cnt >= REQ_DELAY_CYC - 32'h1 && serve_cnt <= REQ_DELAY_CYC + 32'h2)
      else $error("first character at wrong delay");
   AST_EIGHT_MAX: assert property (chars <= 4'h8)
      else $error("more than eight characters");

   COV_SERVE: cover property ($rose(abs_serving));
   COV_EIGHT: cover property (chars == 4'h8);
   COV_ALARM: cover property ($rose(fault_output));
   COV_WARN: cover property ($rose(battery_warning));
endmodule // aerm_monitor_properties

bind aerm_monitor aerm_monitor_properties #(.REQ_DELAY_CYC(REQ_DELAY_CYC)) u_props (
   .aclk(aclk), .aresetn(aresetn), .pins(pins), .char_send_req(char_send_req),
   .abs_serving(abs_serving), .servo_power_en(servo_power_en),
   .fault_output(fault_output), .battery_warning(battery_warning));
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the absolute-encoder request monitor
`timescale 1ns/100ps
`default_nettype none
module testbench
   import aerm_pkg::*;
();
   localparam logic [31:0] TV = 32'h32;
   localparam logic [31:0] TW = 32'h28;
   localparam logic [31:0] TR = 32'h0a;
   logic aclk = 1'b0;
   logic aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic turn_fwd, turn_rev, inc_up, inc_down, want_data, want_servo, power_down, batt_low;
   logic [7:0] awaddr, araddr, done_dly;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, char_done, char_req, serving, servo_en;
   logic fault, warn;
   aerm_pins_t pins;
   int num_errors, num_checks, k, n0;
   int n_chars = 0;

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) if (char_req === 1'b1) n_chars <= n_chars + 1;

   // Short counts keep the run brief; expectations use the same values
   aerm_monitor #(.VALID_CYC(TV), .WINDOW_CYC(TW), .REQ_DELAY_CYC(TR),
      .POST_DELAY_CYC(32'h14)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
      .turn_fwd(turn_fwd), .turn_rev(turn_rev), .inc_up(inc_up), .inc_down(inc_down),
      .char_done(char_done), .char_send_req(char_req), .abs_serving(serving),
      .servo_power_en(servo_en), .fault_output(fault), .battery_warning(warn));

   aerm_host_model u_host (.aclk(aclk), .want_data(want_data), .want_servo(want_servo),
      .power_down(power_down), .batt_low(batt_low), .done_dly(done_dly),
      .char_send_req(char_req), .pins(pins), .char_done(char_done));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic hang();
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 64; i++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 64) hang();
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 64; i++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 64) hang();
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      rd(a, d, r);
      check(d, e);
   endtask

   // Polls STATUS until the masked bits match
   task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
      int i;
      for (i = 0; i < 200; i++)
      begin
         rd(AERM_OFS_STATUS, d, r);
         if ((d & m) === v) break;
      end
      if (i == 200) hang();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, turn_fwd, turn_rev, inc_up} = '0;
      {inc_down, want_data, want_servo, power_down, batt_low} = '0;
      {awaddr, araddr, done_dly, wdata} = '0;
      {num_errors, num_checks} = '0;
      cyc(4);
      aresetn <= 1'b1;
      cyc(2);
      chk_rd(AERM_OFS_STATUS, 32'h00000100);
      chk_rd(AERM_OFS_CFG, 32'h00000000);
      chk_rd(AERM_OFS_T_REQ, TR);
      rd(8'h40, d, r);
      check({30'h0, r}, {30'h0, AERM_RESP_SLVERR});
      wr(8'h44, 32'h1, r);
      check({30'h0, r}, {30'h0, AERM_RESP_SLVERR});
      $display("register test done");
      want_servo <= 1'b1;
      wait_st(32'h00000080, 32'h00000080);
      for (k = 0; k < 2; k++)
      begin
         done_dly <= (k == 0) ? 8'h01 : 8'h06;
         n0 = n_chars;
         inc_up <= 1'b1;
         cyc(3);
         inc_up <= 1'b0;
         inc_down <= 1'b1;
         cyc(1);
         inc_down <= 1'b0;
         want_data <= 1'b1;
         wait_st(32'h00000004, 32'h00000004);
         cyc(2);
         check(32'(servo_en), 32'h0);
         check(32'(serving), 32'h1);
         wait_st(32'h00001f00, 32'h00001000);
         check(32'(n_chars - n0), 32'h8);
         chk_rd(AERM_OFS_INCCNT, 32'h0);
         want_data <= 1'b0;
         wait_st(32'h00001f04, 32'h00000100);
         wait_st(32'h00000080, 32'h00000080);
      end
      $display("request test done");
      turn_fwd <= 1'b1;
      cyc(32767);
      turn_fwd <= 1'b0;
      chk_rd(AERM_OFS_MTURN, 32'h00007fff);
      turn_fwd <= 1'b1;
      cyc(1);
      turn_fwd <= 1'b0;
      chk_rd(AERM_OFS_MTURN, 32'hffff8000);
      turn_rev <= 1'b1;
      cyc(1);
      turn_rev <= 1'b0;
      chk_rd(AERM_OFS_MTURN, 32'h00007fff);
      $display("multiturn test done");
      wr(AERM_OFS_CFG, 32'h1, r);
      chk_rd(AERM_OFS_STATUS, 32'h00000188);
      wr(AERM_OFS_CTRL, 32'h1, r);
      rd(AERM_OFS_STATUS, d, r);
      check(d & 32'h1, 32'h1);
      want_data <= 1'b1;
      batt_low <= 1'b1;
      cyc(int'(TV + TW) + 30);
      rd(AERM_OFS_STATUS, d, r);
      check(d & 32'h64, 32'h0);
      want_data <= 1'b0;
      batt_low <= 1'b0;
      wr(AERM_OFS_CFG, 32'h2, r);
      wr(AERM_OFS_CTRL, 32'h1, r);
      cyc(int'(TV + TW) + 60);
      batt_low <= 1'b1;
      cyc(10);
      check({30'h0, fault, warn}, 32'h1);
      batt_low <= 1'b0;
      wr(AERM_OFS_CFG, 32'h0, r);
      wr(AERM_OFS_CTRL, 32'h1, r);
      cyc(int'(TV + TW) + 60);
      batt_low <= 1'b1;
      cyc(10);
      check({30'h0, fault, warn}, 32'h0);
      batt_low <= 1'b0;
      wr(AERM_OFS_CTRL, 32'h1, r);
      cyc(int'(TV) + 10);
      batt_low <= 1'b1;
      cyc(10);
      check({30'h0, fault, warn}, 32'h2);
      batt_low <= 1'b0;
      wr(AERM_OFS_CTRL, 32'h1, r);
      cyc(10);
      check({30'h0, fault, servo_en}, 32'h2);
      $display("battery test done");
      want_data <= 1'b1;
      cyc(8);
      power_down <= 1'b1;
      cyc(8);
      aresetn <= 1'b0;
      cyc(4);
      aresetn <= 1'b1;
      power_down <= 1'b0;
      want_data <= 1'b0;
      cyc(2);
      check(32'(fault), 32'h0);
      $display("power cycle test done");
      final_report();
   end
endmodule // testbench
`default_nettype wire
